/* design/ctd_decode.sv */
`include "ctd_map.svh"
module ctd_decode (
  input wire logic [5:0] code,
  output logic [14:0] ref_mv10
);
  logic [14:0] idx;
  always_comb
  begin
    idx = {10'h000, code[4:0]};
    if (code[`CTD_CODE_MSB])
      ref_mv10 = 15'(`CTD_REF_HI_BASE - idx * `CTD_REF_HI_STEP);
    else
      ref_mv10 = 15'(`CTD_REF_LO_BASE - idx * `CTD_REF_LO_STEP);
  end
endmodule

/* design/ctd_edge.sv */
module ctd_edge (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic sig,
  output logic rise
);
  typedef struct packed {
    logic prev;
  } ctd_edge_st_t;
  ctd_edge_st_t st_r;
  ctd_edge_st_t st_nxt;
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.prev = sig;
  end
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  assign rise = sig & ~st_r.prev;
endmodule

/* design/ctd_map.svh */
`ifndef CTD_MAP_SVH
`define CTD_MAP_SVH
// Reference in units of 0.1 mV
`define CTD_REF_W 15
`define CTD_REF_LO_BASE 15'h3c8c
`define CTD_REF_LO_STEP 15'h00fa
`define CTD_REF_HI_BASE 15'h1dc9
`define CTD_REF_HI_STEP 15'h007d
`define CTD_CODE_W 6
`define CTD_CODE_MSB 5
`define CTD_RST_REF 15'h0000
`endif

/* design/ctd_pkg.sv */
package ctd_pkg;
  typedef enum logic [1:0] {CTD_IDLE, CTD_PAR, CTD_SER} ctd_mode_t;
endpackage

/* design/ctd_top.sv */
// Behaviour
// - Sample strap once on each enable rising edge and latch protocol.
// - Strap 1 selects parallel code mode, 0 selects serial mode.
// - Parallel mode uses all six code bits as one word for core reference.
// - Parallel mode keeps secondary rail high-impedance, both switch drives off.
// - Parallel mode ignores the processor power-ok input.
// - Parallel mode starts core soft-start without waiting for power-ok.
// - Serial mode ignores code bits 0, 4 and 5.
// - Serial mode routes code bits 2 and 3 onto the serial bus.
// - MSB 0 codes: 1.5500 V down by 25 mV per step.
// - MSB 1 codes: 0.7625 V down by 12.5 mV per step.
// - Parallel mode tracks code changes continuously into the core reference.
`include "ctd_map.svh"
module ctd_top (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic protocol_strap_bit,
  input wire logic voltage_code_bit0,
  input wire logic voltage_code_bit2,
  input wire logic voltage_code_bit3,
  input wire logic voltage_code_bit4,
  input wire logic voltage_code_bit5,
  input wire logic cpu_power_ok,
  output logic parallel_code_mode,
  output logic serial_code_mode,
  output logic [14:0] core_ref,
  output logic core_softstart_go,
  output logic secondary_rail_hs_on,
  output logic secondary_rail_ls_on,
  output logic secondary_rail_hiz,
  output logic serial_clk,
  output logic serial_data
);
  import ctd_pkg::*;

  typedef struct packed {
    ctd_mode_t mode;
    logic par;
    logic ser;
    logic [14:0] ref_val;
    logic go;
    logic hiz;
    logic hs_on;
    logic ls_on;
    logic sclk;
    logic sdat;
  } ctd_st_t;

  ctd_st_t st_r;
  ctd_st_t st_nxt;
  logic en_rise;
  logic [5:0] voltage_code_bus;
  logic [14:0] dec_ref;

  ctd_edge u_edge (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sig(enable),
    .rise(en_rise)
  );

  // Strap pin doubles as code bit 1
  assign voltage_code_bus = {voltage_code_bit5, voltage_code_bit4, voltage_code_bit3,
                             voltage_code_bit2, protocol_strap_bit, voltage_code_bit0};

  ctd_decode u_dec (
    .code(voltage_code_bus),
    .ref_mv10(dec_ref)
  );

  always_comb
  begin
    st_nxt = st_r;
    if (!enable)
    begin
      st_nxt.mode = CTD_IDLE;
    end
    else if (en_rise)
    begin
      st_nxt.mode = protocol_strap_bit ? CTD_PAR : CTD_SER;
    end
    case (st_nxt.mode)
      CTD_PAR:
      begin
        st_nxt.ref_val = dec_ref;
        st_nxt.go = 1'b1;
        st_nxt.hiz = 1'b1;
        st_nxt.hs_on = 1'b0;
        st_nxt.ls_on = 1'b0;
        st_nxt.sclk = 1'b0;
        st_nxt.sdat = 1'b0;
      end
      CTD_SER:
      begin
        st_nxt.ref_val = `CTD_RST_REF;
        st_nxt.go = 1'b0;
        st_nxt.hiz = 1'b0;
        st_nxt.hs_on = 1'b0;
        st_nxt.ls_on = 1'b0;
        st_nxt.sclk = voltage_code_bit2;
        st_nxt.sdat = voltage_code_bit3;
      end
      default:
      begin
        st_nxt.ref_val = `CTD_RST_REF;
        st_nxt.go = 1'b0;
        st_nxt.hiz = 1'b1;
        st_nxt.hs_on = 1'b0;
        st_nxt.ls_on = 1'b0;
        st_nxt.sclk = 1'b0;
        st_nxt.sdat = 1'b0;
      end
    endcase
    st_nxt.par = (st_nxt.mode == CTD_PAR);
    st_nxt.ser = (st_nxt.mode == CTD_SER);
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r.mode <= CTD_IDLE;
      st_r.par <= 1'b0;
      st_r.ser <= 1'b0;
      st_r.ref_val <= `CTD_RST_REF;
      st_r.go <= 1'b0;
      st_r.hiz <= 1'b1;
      st_r.hs_on <= 1'b0;
      st_r.ls_on <= 1'b0;
      st_r.sclk <= 1'b0;
      st_r.sdat <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  assign parallel_code_mode = st_r.par;
  assign serial_code_mode = st_r.ser;
  assign core_ref = st_r.ref_val;
  assign core_softstart_go = st_r.go;
  assign secondary_rail_hiz = st_r.hiz;
  // Switch drives off whenever rail is floated
  assign secondary_rail_hs_on = st_r.hs_on;
  assign secondary_rail_ls_on = st_r.ls_on;
  assign serial_clk = st_r.sclk;
  assign serial_data = st_r.sdat;

  a_strap_latch: assert property (@(posedge ref_clk) disable iff (!rst_b)
    en_rise |=> (parallel_code_mode == $past(protocol_strap_bit)))
    else $error("mode not taken from strap");

  a_rise_once: assert property (@(posedge ref_clk) disable iff (!rst_b)
    en_rise |=> !en_rise)
    else $error("strap sampled twice");

  a_mode_excl: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !(parallel_code_mode && serial_code_mode))
    else $error("both modes set");

  a_par_pick: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (en_rise && protocol_strap_bit) |=> (parallel_code_mode && !serial_code_mode))
    else $error("strap 1 did not select parallel");

  a_ser_pick: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (en_rise && !protocol_strap_bit) |=> (serial_code_mode && !parallel_code_mode))
    else $error("strap 0 did not select serial");

  a_mode_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (parallel_code_mode && enable && !en_rise) |=> parallel_code_mode)
    else $error("mode changed without edge");

  a_ser_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (serial_code_mode && enable && !en_rise) |=> serial_code_mode)
    else $error("serial mode lost without edge");

  a_strap_ignored: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (enable && !en_rise && $changed(protocol_strap_bit)) |=>
    ($stable(parallel_code_mode) && $stable(serial_code_mode)))
    else $error("late strap change altered mode");

  a_idle_drop: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !enable |=> (!parallel_code_mode && !serial_code_mode && core_ref == 15'h0000))
    else $error("outputs not idle with enable low");

  a_ref_track: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_nxt.mode == CTD_PAR) |=> (core_ref == $past(dec_ref)))
    else $error("reference not tracking code");

  a_pok_ignore: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (parallel_code_mode && enable && !en_rise && $stable(voltage_code_bus)) |=>
    ($stable(core_ref) && core_softstart_go))
    else $error("reference moved without code change");

  a_ref_range: assert property (@(posedge ref_clk) disable iff (!rst_b)
    parallel_code_mode |-> (core_ref >= 15'h0ea6 && core_ref <= 15'h3c8c))
    else $error("reference outside code table");

  a_lo_linear: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_nxt.mode == CTD_PAR && !voltage_code_bus[5]) |=>
    (core_ref == 15'(15'h3c8c - 15'h00fa * $past(voltage_code_bus[4:0]))))
    else $error("upper half step wrong");

  a_hi_linear: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_nxt.mode == CTD_PAR && voltage_code_bus[5]) |=>
    (core_ref == 15'(15'h1dc9 - 15'h007d * $past(voltage_code_bus[4:0]))))
    else $error("lower half step wrong");

  a_ref_top: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_nxt.mode == CTD_PAR && voltage_code_bus == 6'h00) |=> (core_ref == 15'h3c8c))
    else $error("code 0 reference wrong");

  a_ref_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_nxt.mode == CTD_PAR && voltage_code_bus == 6'h3f) |=> (core_ref == 15'h0ea6))
    else $error("code 63 reference wrong");

  a_ref_mid: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_nxt.mode == CTD_PAR && voltage_code_bus == 6'h1f) |=> (core_ref == 15'h1e46))
    else $error("code 31 reference wrong");

  a_ref_c01: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_nxt.mode == CTD_PAR && voltage_code_bus == 6'h01) |=> (core_ref == 15'h3b92))
    else $error("code 1 reference wrong");

  a_ref_c02: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_nxt.mode == CTD_PAR && voltage_code_bus == 6'h02) |=> (core_ref == 15'h3a98))
    else $error("code 2 reference wrong");

  a_ref_c04: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_nxt.mode == CTD_PAR && voltage_code_bus == 6'h04) |=> (core_ref == 15'h38a4))
    else $error("code 4 reference wrong");

  a_ref_c08: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_nxt.mode == CTD_PAR && voltage_code_bus == 6'h08) |=> (core_ref == 15'h34bc))
    else $error("code 8 reference wrong");

  a_ref_c10: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_nxt.mode == CTD_PAR && voltage_code_bus == 6'h10) |=> (core_ref == 15'h2cec))
    else $error("code 16 reference wrong");

  a_ref_c20: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_nxt.mode == CTD_PAR && voltage_code_bus == 6'h20) |=> (core_ref == 15'h1dc9))
    else $error("code 32 reference wrong");

  a_ref_c21: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_nxt.mode == CTD_PAR && voltage_code_bus == 6'h21) |=> (core_ref == 15'h1d4c))
    else $error("code 33 reference wrong");

  a_ref_c22: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_nxt.mode == CTD_PAR && voltage_code_bus == 6'h22) |=> (core_ref == 15'h1ccf))
    else $error("code 34 reference wrong");

  a_ref_c24: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_nxt.mode == CTD_PAR && voltage_code_bus == 6'h24) |=> (core_ref == 15'h1bd5))
    else $error("code 36 reference wrong");

  a_ref_c28: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_nxt.mode == CTD_PAR && voltage_code_bus == 6'h28) |=> (core_ref == 15'h19e1))
    else $error("code 40 reference wrong");

  a_ref_c30: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_nxt.mode == CTD_PAR && voltage_code_bus == 6'h30) |=> (core_ref == 15'h15f9))
    else $error("code 48 reference wrong");

  a_sec_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
    parallel_code_mode |-> (secondary_rail_hiz && !secondary_rail_hs_on && !secondary_rail_ls_on))
    else $error("secondary rail active");

  a_go_nopok: assert property (@(posedge ref_clk) disable iff (!rst_b)
    parallel_code_mode |-> core_softstart_go)
    else $error("soft-start waits on power-ok");

  a_go_first: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (en_rise && protocol_strap_bit) |=> core_softstart_go)
    else $error("soft-start late after detection");

  a_go_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !parallel_code_mode |-> !core_softstart_go)
    else $error("soft-start outside parallel mode");

  a_ser_ref_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
    serial_code_mode |-> (core_ref == 15'h0000 && !core_softstart_go))
    else $error("parallel code used in serial mode");

  a_ser_ignore: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (serial_code_mode && enable && !en_rise && $stable(voltage_code_bit2) && $stable(voltage_code_bit3)) |=>
    $stable({serial_clk, serial_data, core_ref}))
    else $error("ignored code bits reached outputs");

  a_serial_map: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_nxt.mode == CTD_SER) |=> (serial_clk == $past(voltage_code_bit2) && serial_data == $past(voltage_code_bit3)))
    else $error("serial pins not routed");

  a_sclk_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !serial_code_mode |-> (!serial_clk && !serial_data))
    else $error("serial pins active outside serial mode");

  c_par: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(parallel_code_mode));
  c_ser: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(serial_code_mode));
  c_code_chg: cover property (@(posedge ref_clk) disable iff (!rst_b)
    parallel_code_mode && $changed(core_ref));
  c_strap_flip: cover property (@(posedge ref_clk) disable iff (!rst_b) parallel_code_mode && $changed(protocol_strap_bit));
  c_ser_drop: cover property (@(posedge ref_clk) disable iff (!rst_b) $fell(serial_code_mode));
endmodule

/* test/ctd_cpu_model.sv */
module ctd_cpu_model (
  input wire logic [5:0] code,
  output logic strap,
  output logic b0,
  output logic b2,
  output logic b3,
  output logic b4,
  output logic b5
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pins follow the code word; the bench keeps the strap steady at enable rise
  assign {b5, b4, b3, b2, strap, b0} = code;
endmodule

/* test/tb_cpu_type_detect_parallel_vid.sv */
module tb_cpu_type_detect_parallel_vid;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst_b = 0, enable = 0, pok = 0;
  logic [5:0] code = 6'h00;
  logic strap, b0, b2, b3, b4, b5, pm, sm, go, hs, ls, hiz, sclk, sdat;
  logic [14:0] core_ref;
  int errors = 0, checked = 0, cyc = 0;
  ctd_cpu_model cpu (.code(code), .strap(strap), .b0(b0), .b2(b2), .b3(b3), .b4(b4), .b5(b5));
  ctd_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .enable(enable), .protocol_strap_bit(strap),
    .voltage_code_bit0(b0), .voltage_code_bit2(b2), .voltage_code_bit3(b3), .voltage_code_bit4(b4),
    .voltage_code_bit5(b5), .cpu_power_ok(pok), .parallel_code_mode(pm), .serial_code_mode(sm),
    .core_ref(core_ref), .core_softstart_go(go), .secondary_rail_hs_on(hs),
    .secondary_rail_ls_on(ls), .secondary_rail_hiz(hiz), .serial_clk(sclk), .serial_data(sdat));
  initial forever #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      errors++;
      report_and_stop();
    end
  end
  task report_and_stop();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [19:0] exp, input logic [19:0] got);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // Drop enable, check idle, then raise enable with the wanted strap
  task start(input logic s);
    @(negedge ref_clk);
    enable = 0;
    @(negedge ref_clk);
    chk(20'h0, {pm, sm, go, core_ref});
    code = {4'h0, s, 1'b0};
    enable = 1;
    @(negedge ref_clk);
  endtask
  task t_par();
    start(1'b1);
    chk(20'h2c, {pm, sm, go, hiz, hs, ls});
    for (int i = 0; i < 64; i++)
    begin
      code = i[5:0];
      pok = i[0];
      @(negedge ref_clk);
      chk(15'(i < 32 ? 15500 - 250 * i : 7625 - 125 * (i - 32)), core_ref);
      chk(20'h3, {pm, go});
    end
    $display("parallel test done");
  endtask
  task t_ser();
    start(1'b0);
    chk(20'h08, {pm, sm, hiz, hs, ls});
    for (int i = 0; i < 64; i++)
    begin
      code = i[5:0];
      @(negedge ref_clk);
      @(negedge ref_clk);
      chk({3'h1, i[2], i[3], 15'h0}, {sm, sclk, sdat, core_ref});
    end
    $display("serial test done");
  endtask
  // Mid-run reset with enable held high re-detects on release
  task t_rst();
    @(negedge ref_clk);
    rst_b = 0;
    @(negedge ref_clk);
    chk(20'h1, {pm, sm, go, hiz});
    chk(20'h0, {sclk, sdat, core_ref});
    rst_b = 1;
    @(negedge ref_clk);
    chk(20'h3, {pm, go});
    pok = ~pok;
    repeat (2) @(negedge ref_clk);
    chk(20'h0ea6, core_ref);
    $display("reset test done");
  endtask
  initial
  begin
    repeat (6) @(negedge ref_clk);
    chk(20'h1, {pm, sm, go, hiz});
    rst_b = 1;
    t_par();
    t_ser();
    t_par();
    t_rst();
    report_and_stop();
  end
endmodule
